// File: common/auto_clock_defs.svh
// register offsets, field positions, reset values and limits of the clock block
`ifndef AUTO_CLOCK_DEFS_SVH
`define AUTO_CLOCK_DEFS_SVH

// register offsets on the control interface
`define ADDR_DIV_STATUS   7'h04
`define ADDR_DAC_CTRL_TWO 7'h06
`define ADDR_OVERRIDE     7'h08
`define ADDR_EXTRA_ONE    7'h17
`define ADDR_RATE_CTRL    7'h1B
`define ADDR_RATIO_CTRL   7'h38

// field positions
`define DAC_OSR_BIT   0
`define ADC_OSR_BIT   5
`define INT_MODE_BIT  4
`define RATE_MSB      2
`define RATE_LSB      0
`define RATIO_MSB     4
`define RATIO_LSB     1
`define PDIV_MSB      10
`define PDIV_LSB      9
`define ADIV_MSB      8
`define ADIV_LSB      6
`define DDIV_MSB      5
`define DDIV_LSB      3
`define OVR_BIT       11
`define SRC_MSB       10
`define SRC_LSB       9
`define OSC_BIT       12
`define CO5_SEL_BIT   13
`define SYN2_BIT      14
`define SYN3_BIT      15
`define CO2_DIV_BIT   1
`define CO5_DIV_BIT   2
`define CO3_SEL_BIT   3

// reset values
`define RATE_RST      3'h0
`define INT_MODE_RST  1'h1
`define RATIO_RST     4'h3
`define PDIV_RST      2'h0
`define ADIV_RST      3'h0
`define DDIV_RST      3'h4
`define SRC_RST       2'h0

// reserved codes
`define RATE_RSVD     3'h7
`define RATIO_RSVD    4'h8

// master source codes
`define SRC_FLL       2'h1

// locked values while the pin owns the clocking registers
`define LOCK_SYN2     1'h0
`define LOCK_SYN3     1'h0
`define LOCK_CO2_DIV  1'h0
`define LOCK_CO5_DIV  1'h0
`define LOCK_CO3_SEL  1'h0

// converter divider codes
`define CDIV_1        3'h0
`define CDIV_2        3'h2
`define CDIV_3        3'h3
`define CDIV_4        3'h4
`define CDIV_6        3'h6

// processing divider codes
`define PDIV_1        2'h0
`define PDIV_2        2'h1
`define PDIV_4        2'h2

// processing clock ceiling and oversampling ratios
`define PROC_MAX_HZ   32'd24576000
`define OSR_LOW       32'd64
`define OSR_HIGH      32'd128

`endif

// File: common/auto_clock_pkg.sv
// types and lookup functions of the automatic clock configuration
`include "auto_clock_defs.svh"

package auto_clock_pkg;

	typedef logic [2:0] cdiv_code_t;
	typedef logic [1:0] pdiv_code_t;

	// sample rate in Hz; unpaired codes keep their one rate in either family
	function automatic logic [31:0] fs_hz(input logic [2:0] code,
		input logic int_mode);
		logic [31:0] r;
		r = 32'd48000;
		unique case (code)
			3'h0: r = int_mode ? 32'd48000 : 32'd44100;
			3'h1: r = 32'd32000;
			3'h2: r = int_mode ? 32'd24000 : 32'd22050;
			3'h3: r = 32'd16000;
			3'h4: r = int_mode ? 32'd12000 : 32'd11025;
			3'h5: r = 32'd8000;
			3'h6: r = int_mode ? 32'd96000 : 32'd88200;
			default: r = 32'd48000;
		endcase
		return r;
	endfunction

	// master clock per sample for each ratio code
	function automatic logic [31:0] ratio_val(input logic [3:0] code);
		logic [31:0] r;
		r = 32'd256;
		unique case (code)
			4'h0: r = 32'd64;
			4'h1: r = 32'd128;
			4'h2: r = 32'd192;
			4'h3: r = 32'd256;
			4'h4: r = 32'd384;
			4'h5: r = 32'd512;
			4'h6: r = 32'd768;
			4'h7: r = 32'd1024;
			4'h9: r = 32'd1536;
			4'hA: r = 32'd3072;
			4'hB: r = 32'd6144;
			default: r = 32'd256;
		endcase
		return r;
	endfunction

	// divide count carried by a converter divider code
	function automatic logic [2:0] cdiv_count(input cdiv_code_t code);
		logic [2:0] n;
		n = 3'h1;
		unique case (code)
			`CDIV_2: n = 3'h2;
			`CDIV_3: n = 3'h3;
			`CDIV_4: n = 3'h4;
			`CDIV_6: n = 3'h6;
			default: n = 3'h1;
		endcase
		return n;
	endfunction

endpackage

// File: common/rate_tick_if.sv
// carrier between the control logic and one rate divider
`timescale 1ns/10ps
`default_nettype none

interface rate_tick_if;
	logic [2:0] divide_by;  // 1..6, one cycle of output per this many inputs
	logic       source_en;  // input rate enable
	logic       tick;       // output rate enable pulse

	modport divider (input divide_by, input source_en, output tick);
	modport control (output divide_by, output source_en, input tick);
endinterface

`default_nettype wire

// File: src/pin_sync.sv
// two-stage synchroniser for the multipurpose pin
`timescale 1ns/10ps
`default_nettype none

module pin_sync
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// pin in, synchronised level out
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= 1'b0;
			sync_o <= 1'b0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule

`default_nettype wire

// File: src/rate_divider.sv
// enable-pulse divider: one tick per divide_by source enables
`timescale 1ns/10ps
`default_nettype none

module rate_divider
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// divider carrier
	rate_tick_if.divider port
);

	logic [2:0] count_q;
	logic       last;

	assign last = (count_q >= port.divide_by - 3'h1);
	// >= keeps a shrinking divisor from running past its end
	assign port.tick = port.source_en & last;

	// count source enables, wrap on the last one
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_q <= 3'h0;
		else if (port.source_en)
			count_q <= last ? 3'h0 : count_q + 3'h1;
	end

endmodule

`default_nettype wire

// File: src/auto_clock_config.sv
// automatic clock configuration: setting registers, derived dividers, ticks
//
// How it works
// - sample rates from 8kHz to 96kHz serve both converters.
// - three-bit rate code picks the fs pair; code 111 is reserved.
// - family bit picks fractional (0) or integer (1) rate of a pair.
// - one common sample rate drives both ADC and DAC.
// - four-bit ratio code gives master clock per sample; 1000 reserved.
// - per-converter oversampling bit: 0 low power 64fs, 1 high 128fs.
// - oversampling bits steer the converter divider choice.
// - override low: pin owns source, oscillator, output five select.
// - processing divider is the smallest of 1, 2, 4 keeping processing clock at most 24.576MHz; by four when none does.
// - processing divider codes: 00 undivided, 01 by two, 10 by four.
// - ADC and DAC each get their own divider from the processing clock.
// - ADC divider codes 000,010,011,100,110; reset 000.
// - DAC divider uses the same codes; reset 100, divide by four.
// - derived divider fields read back only; writes have no effect.
// - dividers follow from rate, ratio and oversampling settings only.
// - override low and pin high force FREQUENCY_LOCKED_LOOP source, write-protected.
`timescale 1ns/10ps
`default_nettype none

`include "auto_clock_defs.svh"

module auto_clock_config
(
	// clock and reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_N_I,
	// control interface register port
	input  wire logic        REG_WR_I,
	input  wire logic [6:0]  REG_ADDR_I,
	input  wire logic [15:0] REG_WDATA_I,
	output logic      [15:0] REG_RDATA_O,
	// multipurpose pin five, asynchronous
	input  wire logic        PIN_FIVE_I,
	// effective clocking controls
	output logic      [1:0]  MASTER_SOURCE_SELECT_O,
	output logic             OSCILLATOR_ENABLE_O,
	output logic             CLOCK_OUTPUT_FIVE_SELECT_O,
	output logic             SECOND_SYNTH_ENABLE_O,
	output logic             THIRD_SYNTH_ENABLE_O,
	output logic             CLOCK_OUTPUT_TWO_DIVIDER_O,
	output logic             CLOCK_OUTPUT_FIVE_DIVIDER_O,
	output logic             CLOCK_OUTPUT_THREE_SELECT_O,
	// derived rate enables
	output logic             PROCESSING_TICK_O,
	output logic             ADC_TICK_O,
	output logic             DAC_TICK_O
);

	// setting registers
	logic [2:0] rate_q;
	logic       int_mode_q;
	logic [3:0] ratio_q;
	logic       adc_osr_q;
	logic       dac_osr_q;
	logic       ovr_q;
	logic [1:0] src_q;
	logic       osc_q;
	logic       co5_sel_q;
	logic       syn2_q;
	logic       syn3_q;
	logic       co2_div_q;
	logic       co5_div_q;
	logic       co3_sel_q;

	// derived dividers and recompute request
	auto_clock_pkg::pdiv_code_t pdiv_q;
	auto_clock_pkg::pdiv_code_t pdiv_d;
	auto_clock_pkg::cdiv_code_t adiv_q;
	auto_clock_pkg::cdiv_code_t adiv_d;
	auto_clock_pkg::cdiv_code_t ddiv_q;
	auto_clock_pkg::cdiv_code_t ddiv_d;
	logic                       recompute_q;

	logic        pin5;
	logic        pin_owns;
	logic        src_locked;
	logic [31:0] mclk_hz;
	logic [31:0] sys_ratio;

	// write strobes per register
	logic wr_dac2;
	logic wr_ovr;
	logic wr_ext1;
	logic wr_rate;
	logic wr_ratio;

	assign wr_dac2  = REG_WR_I && (REG_ADDR_I == `ADDR_DAC_CTRL_TWO);
	assign wr_ovr   = REG_WR_I && (REG_ADDR_I == `ADDR_OVERRIDE);
	assign wr_ext1  = REG_WR_I && (REG_ADDR_I == `ADDR_EXTRA_ONE);
	assign wr_rate  = REG_WR_I && (REG_ADDR_I == `ADDR_RATE_CTRL);
	assign wr_ratio = REG_WR_I && (REG_ADDR_I == `ADDR_RATIO_CTRL);

	// pin passes two flops before anything looks at it
	pin_sync u_pin_sync
	(
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.async_i (PIN_FIVE_I),
		.sync_o  (pin5)
	);

	assign pin_owns   = !ovr_q;
	assign src_locked = pin_owns && pin5;

	// sample rate and oversampling settings
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			rate_q     <= `RATE_RST;
			int_mode_q <= `INT_MODE_RST;
			ratio_q    <= `RATIO_RST;
			adc_osr_q  <= 1'b0;
			dac_osr_q  <= 1'b0;
		end
		else
		begin
			if (wr_rate)
			begin
				rate_q     <= REG_WDATA_I[`RATE_MSB:`RATE_LSB];
				int_mode_q <= REG_WDATA_I[`INT_MODE_BIT];
			end
			if (wr_ratio)
				ratio_q <= REG_WDATA_I[`RATIO_MSB:`RATIO_LSB];
			if (wr_ext1)
				adc_osr_q <= REG_WDATA_I[`ADC_OSR_BIT];
			if (wr_dac2)
				dac_osr_q <= REG_WDATA_I[`DAC_OSR_BIT];
		end
	end

	// override register; the source field is frozen while the pin forces it
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ovr_q     <= 1'b0;
			src_q     <= `SRC_RST;
			osc_q     <= 1'b0;
			co5_sel_q <= 1'b0;
			syn2_q    <= 1'b0;
			syn3_q    <= 1'b0;
			co2_div_q <= 1'b0;
			co5_div_q <= 1'b0;
			co3_sel_q <= 1'b0;
		end
		else if (wr_ovr)
		begin
			ovr_q <= REG_WDATA_I[`OVR_BIT];
			if (!src_locked)
				src_q <= REG_WDATA_I[`SRC_MSB:`SRC_LSB];
			osc_q     <= REG_WDATA_I[`OSC_BIT];
			co5_sel_q <= REG_WDATA_I[`CO5_SEL_BIT];
			syn2_q    <= REG_WDATA_I[`SYN2_BIT];
			syn3_q    <= REG_WDATA_I[`SYN3_BIT];
			co2_div_q <= REG_WDATA_I[`CO2_DIV_BIT];
			co5_div_q <= REG_WDATA_I[`CO5_DIV_BIT];
			co3_sel_q <= REG_WDATA_I[`CO3_SEL_BIT];
		end
	end

	// effective controls: pin or locked values while the override is low
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			MASTER_SOURCE_SELECT_O      <= `SRC_RST;
			OSCILLATOR_ENABLE_O         <= 1'b0;
			CLOCK_OUTPUT_FIVE_SELECT_O  <= 1'b0;
			SECOND_SYNTH_ENABLE_O       <= `LOCK_SYN2;
			THIRD_SYNTH_ENABLE_O        <= `LOCK_SYN3;
			CLOCK_OUTPUT_TWO_DIVIDER_O  <= `LOCK_CO2_DIV;
			CLOCK_OUTPUT_FIVE_DIVIDER_O <= `LOCK_CO5_DIV;
			CLOCK_OUTPUT_THREE_SELECT_O <= `LOCK_CO3_SEL;
		end
		else if (pin_owns)
		begin
			MASTER_SOURCE_SELECT_O      <= pin5 ? `SRC_FLL : src_q;
			OSCILLATOR_ENABLE_O         <= pin5;
			CLOCK_OUTPUT_FIVE_SELECT_O  <= pin5;
			SECOND_SYNTH_ENABLE_O       <= `LOCK_SYN2;
			THIRD_SYNTH_ENABLE_O        <= `LOCK_SYN3;
			CLOCK_OUTPUT_TWO_DIVIDER_O  <= `LOCK_CO2_DIV;
			CLOCK_OUTPUT_FIVE_DIVIDER_O <= `LOCK_CO5_DIV;
			CLOCK_OUTPUT_THREE_SELECT_O <= `LOCK_CO3_SEL;
		end
		else
		begin
			MASTER_SOURCE_SELECT_O      <= src_q;
			OSCILLATOR_ENABLE_O         <= osc_q;
			CLOCK_OUTPUT_FIVE_SELECT_O  <= co5_sel_q;
			SECOND_SYNTH_ENABLE_O       <= syn2_q;
			THIRD_SYNTH_ENABLE_O        <= syn3_q;
			CLOCK_OUTPUT_TWO_DIVIDER_O  <= co2_div_q;
			CLOCK_OUTPUT_FIVE_DIVIDER_O <= co5_div_q;
			CLOCK_OUTPUT_THREE_SELECT_O <= co3_sel_q;
		end
	end

	// one cycle after any settings write, fold the new values in
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			recompute_q <= 1'b0;
		else
			recompute_q <= wr_rate | wr_ratio | wr_ext1 | wr_dac2;
	end

	// master frequency from one common fs and the ratio
	assign mclk_hz = auto_clock_pkg::fs_hz(rate_q, int_mode_q)
		* auto_clock_pkg::ratio_val(ratio_q);

	// smallest divide that keeps the processing clock at or under the ceiling; divide by four when none does
	always_comb
	begin
		if (mclk_hz <= `PROC_MAX_HZ)
			pdiv_d = `PDIV_1;
		else if (mclk_hz <= (`PROC_MAX_HZ << 1))
			pdiv_d = `PDIV_2;
		else
			pdiv_d = `PDIV_4;
	end

	// system clock per sample after the processing divide
	always_comb
	begin
		unique case (pdiv_d)
			`PDIV_2: sys_ratio = auto_clock_pkg::ratio_val(ratio_q) >> 1;
			`PDIV_4: sys_ratio = auto_clock_pkg::ratio_val(ratio_q) >> 2;
			default: sys_ratio = auto_clock_pkg::ratio_val(ratio_q);
		endcase
	end

	// largest divide that still leaves the converter its oversampling rate
	function automatic auto_clock_pkg::cdiv_code_t pick_cdiv(
		input logic [31:0] ratio,
		input logic        high_perf);
		logic [31:0] osr;
		auto_clock_pkg::cdiv_code_t c;
		osr = high_perf ? `OSR_HIGH : `OSR_LOW;
		if (ratio >= osr * 32'd6)
			c = `CDIV_6;
		else if (ratio >= osr * 32'd4)
			c = `CDIV_4;
		else if (ratio >= osr * 32'd3)
			c = `CDIV_3;
		else if (ratio >= osr * 32'd2)
			c = `CDIV_2;
		else
			c = `CDIV_1;
		return c;
	endfunction

	assign adiv_d = pick_cdiv(sys_ratio, adc_osr_q);
	assign ddiv_d = pick_cdiv(sys_ratio, dac_osr_q);

	// derived dividers: only the automatic logic loads them; reserved
	// settings keep the last good dividers so the clocks never glitch
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			pdiv_q <= `PDIV_RST;
			adiv_q <= `ADIV_RST;
			ddiv_q <= `DDIV_RST;
		end
		else if (recompute_q && (rate_q != `RATE_RSVD)
			&& (ratio_q != `RATIO_RSVD))
		begin
			pdiv_q <= pdiv_d;
			adiv_q <= adiv_d;
			ddiv_q <= ddiv_d;
		end
	end

	// rate dividers: processing from the master, converters from it
	rate_tick_if proc_if ();
	rate_tick_if adc_if ();
	rate_tick_if dac_if ();

	assign proc_if.source_en = 1'b1;
	assign proc_if.divide_by = (pdiv_q == `PDIV_4) ? 3'h4
		: (pdiv_q == `PDIV_2) ? 3'h2 : 3'h1;
	assign adc_if.source_en  = proc_if.tick;
	assign adc_if.divide_by  = auto_clock_pkg::cdiv_count(adiv_q);
	assign dac_if.source_en  = proc_if.tick;
	assign dac_if.divide_by  = auto_clock_pkg::cdiv_count(ddiv_q);

	rate_divider u_proc_div
	(
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.port    (proc_if)
	);

	rate_divider u_adc_div
	(
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.port    (adc_if)
	);

	rate_divider u_dac_div
	(
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.port    (dac_if)
	);

	assign PROCESSING_TICK_O = proc_if.tick;
	assign ADC_TICK_O        = adc_if.tick;
	assign DAC_TICK_O        = dac_if.tick;

	// registered read-back; unmapped addresses and spare bits read zero
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			REG_RDATA_O <= 16'h0000;
		else
		begin
			REG_RDATA_O <= 16'h0000;
			unique case (REG_ADDR_I)
				`ADDR_DIV_STATUS:
				begin
					REG_RDATA_O[`PDIV_MSB:`PDIV_LSB] <= pdiv_q;
					REG_RDATA_O[`ADIV_MSB:`ADIV_LSB] <= adiv_q;
					REG_RDATA_O[`DDIV_MSB:`DDIV_LSB] <= ddiv_q;
				end
				`ADDR_DAC_CTRL_TWO:
					REG_RDATA_O[`DAC_OSR_BIT] <= dac_osr_q;
				`ADDR_OVERRIDE:
				begin
					REG_RDATA_O[`OVR_BIT]         <= ovr_q;
					REG_RDATA_O[`SRC_MSB:`SRC_LSB] <= MASTER_SOURCE_SELECT_O;
					REG_RDATA_O[`OSC_BIT]         <= OSCILLATOR_ENABLE_O;
					REG_RDATA_O[`CO5_SEL_BIT]     <= CLOCK_OUTPUT_FIVE_SELECT_O;
					REG_RDATA_O[`SYN2_BIT]        <= SECOND_SYNTH_ENABLE_O;
					REG_RDATA_O[`SYN3_BIT]        <= THIRD_SYNTH_ENABLE_O;
					REG_RDATA_O[`CO2_DIV_BIT]     <= CLOCK_OUTPUT_TWO_DIVIDER_O;
					REG_RDATA_O[`CO5_DIV_BIT]     <= CLOCK_OUTPUT_FIVE_DIVIDER_O;
					REG_RDATA_O[`CO3_SEL_BIT]     <= CLOCK_OUTPUT_THREE_SELECT_O;
				end
				`ADDR_EXTRA_ONE:
					REG_RDATA_O[`ADC_OSR_BIT] <= adc_osr_q;
				`ADDR_RATE_CTRL:
				begin
					REG_RDATA_O[`INT_MODE_BIT]       <= int_mode_q;
					REG_RDATA_O[`RATE_MSB:`RATE_LSB] <= rate_q;
				end
				`ADDR_RATIO_CTRL:
					REG_RDATA_O[`RATIO_MSB:`RATIO_LSB] <= ratio_q;
				default:
					REG_RDATA_O <= 16'h0000;
			endcase
		end
	end

endmodule

`default_nettype wire

// File: verification/auto_clock_config_checker.sv
// port-level assertions for the automatic clock configuration block
`timescale 1ns/10ps
`default_nettype none

module auto_clock_config_checker
(
	// clock and reset
	input wire logic        SYS_CLK_I,
	input wire logic        RST_N_I,
	// register port and pin
	input wire logic        REG_WR_I,
	input wire logic [6:0]  REG_ADDR_I,
	input wire logic [15:0] REG_WDATA_I,
	input wire logic [15:0] REG_RDATA_O,
	input wire logic        PIN_FIVE_I,
	// effective controls
	input wire logic [1:0]  MASTER_SOURCE_SELECT_O,
	input wire logic        OSCILLATOR_ENABLE_O,
	input wire logic        CLOCK_OUTPUT_FIVE_SELECT_O,
	input wire logic        SECOND_SYNTH_ENABLE_O,
	input wire logic        THIRD_SYNTH_ENABLE_O,
	input wire logic        CLOCK_OUTPUT_TWO_DIVIDER_O,
	input wire logic        CLOCK_OUTPUT_FIVE_DIVIDER_O,
	input wire logic        CLOCK_OUTPUT_THREE_SELECT_O,
	// rate enables
	input wire logic        PROCESSING_TICK_O,
	input wire logic        ADC_TICK_O,
	input wire logic        DAC_TICK_O
);
	logic        ovr_q;
	logic [15:0] wd_q;
	logic        pin_s1;
	logic        pin_s2;
	logic [1:0]  src_s;

	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);

	// shadow of the override bit and last written word; the override bit
	// is writable in every state, so a plain copy is enough
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ovr_q <= 1'h0;
			wd_q  <= 16'h0000;
		end
		else if (REG_WR_I)
		begin
			wd_q <= REG_WDATA_I;
			if (REG_ADDR_I == 7'h08)
				ovr_q <= REG_WDATA_I[11];
		end
	end

	// pin seen through two flops as the device must see it; the stored
	// source refuses a write while the pin is forcing it
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			src_s  <= 2'h0;
		end
		else
		begin
			pin_s1 <= PIN_FIVE_I;
			pin_s2 <= pin_s1;
			if (REG_WR_I && REG_ADDR_I == 7'h08 && (ovr_q || !pin_s2))
				src_s <= REG_WDATA_I[10:9];
		end
	end

	// multi-step behaviours
	sequence pin_high_held;
		(!ovr_q && PIN_FIVE_I) [*5];
	endsequence
	sequence pin_low_held;
		(!ovr_q && !PIN_FIVE_I) [*5];
	endsequence
	sequence ovr_write;
		REG_WR_I && REG_ADDR_I == 7'h08 && REG_WDATA_I[11];
	endsequence
	sequence ratio_write_read;
		(REG_WR_I && REG_ADDR_I == 7'h38) ##1 (REG_ADDR_I == 7'h38);
	endsequence

	chk_adc_on_proc: assert property (ADC_TICK_O |-> PROCESSING_TICK_O)
		else $error("adc tick outside a processing tick");
	chk_dac_on_proc: assert property (DAC_TICK_O |-> PROCESSING_TICK_O)
		else $error("dac tick outside a processing tick");
	chk_proc_period: assert property (PROCESSING_TICK_O |=> ##[0:3] PROCESSING_TICK_O)
		else $error("processing tick gap above four");
	chk_dac_period: assert property (DAC_TICK_O |=> ##[0:47] DAC_TICK_O)
		else $error("dac tick gap too long");
	chk_locked_fixed: assert property ((!ovr_q && !$past(ovr_q)) |->
		{SECOND_SYNTH_ENABLE_O, THIRD_SYNTH_ENABLE_O, CLOCK_OUTPUT_TWO_DIVIDER_O,
		CLOCK_OUTPUT_FIVE_DIVIDER_O, CLOCK_OUTPUT_THREE_SELECT_O} == 5'h00)
		else $error("locked controls not at fixed value");
	chk_pin_forces_fll: assert property (pin_high_held |->
		MASTER_SOURCE_SELECT_O == 2'h1 && OSCILLATOR_ENABLE_O
		&& CLOCK_OUTPUT_FIVE_SELECT_O)
		else $error("pin high did not force source");
	chk_pin_low_follow: assert property (pin_low_held |->
		!OSCILLATOR_ENABLE_O && !CLOCK_OUTPUT_FIVE_SELECT_O)
		else $error("pin low not followed");
	chk_ovr_normal: assert property (ovr_write |-> ##2
		(MASTER_SOURCE_SELECT_O == src_s
		&& OSCILLATOR_ENABLE_O == wd_q[12]
		&& CLOCK_OUTPUT_FIVE_SELECT_O == wd_q[13]
		&& SECOND_SYNTH_ENABLE_O == wd_q[14] && THIRD_SYNTH_ENABLE_O == wd_q[15]
		&& CLOCK_OUTPUT_TWO_DIVIDER_O == wd_q[1]
		&& CLOCK_OUTPUT_FIVE_DIVIDER_O == wd_q[2]
		&& CLOCK_OUTPUT_THREE_SELECT_O == wd_q[3]))
		else $error("override write not reflected");
	chk_ratio_readback: assert property (ratio_write_read |=> REG_RDATA_O[4:1] == wd_q[4:1])
		else $error("ratio read back wrong");
endmodule

bind auto_clock_config auto_clock_config_checker checker_inst
(
	.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I),
	.REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
	.REG_RDATA_O(REG_RDATA_O), .PIN_FIVE_I(PIN_FIVE_I),
	.MASTER_SOURCE_SELECT_O(MASTER_SOURCE_SELECT_O),
	.OSCILLATOR_ENABLE_O(OSCILLATOR_ENABLE_O),
	.CLOCK_OUTPUT_FIVE_SELECT_O(CLOCK_OUTPUT_FIVE_SELECT_O),
	.SECOND_SYNTH_ENABLE_O(SECOND_SYNTH_ENABLE_O),
	.THIRD_SYNTH_ENABLE_O(THIRD_SYNTH_ENABLE_O),
	.CLOCK_OUTPUT_TWO_DIVIDER_O(CLOCK_OUTPUT_TWO_DIVIDER_O),
	.CLOCK_OUTPUT_FIVE_DIVIDER_O(CLOCK_OUTPUT_FIVE_DIVIDER_O),
	.CLOCK_OUTPUT_THREE_SELECT_O(CLOCK_OUTPUT_THREE_SELECT_O),
	.PROCESSING_TICK_O(PROCESSING_TICK_O), .ADC_TICK_O(ADC_TICK_O),
	.DAC_TICK_O(DAC_TICK_O)
);

`default_nettype wire

// File: verification/pin_five_source.sv
// board-side source of the multipurpose pin five level
`timescale 1ns/10ps
`default_nettype none

module pin_five_source
(
	// level asked for by the host side
	input  wire logic level_i,
	// pin as the device sees it
	output logic      pin_o
);
	// change well away from the clock edge so the device must synchronise
	always @(level_i)
	begin
		pin_o <= #13 level_i;
	end

	// pin starts low
	initial
	begin
		pin_o = 1'b0;
	end
endmodule

`default_nettype wire

// File: verification/testbench.sv
// self-checking bench of the automatic clock configuration block
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic        clk;
	logic        rst_n;
	logic        wr;
	logic [6:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        pin_level;
	logic        pin;
	logic [1:0]  src;
	logic        osc, co5s, syn2, syn3, co2d, co5d, co3s;
	logic        ptick, atick, dtick;
	logic [8:0]  eff;
	logic [15:0] n_adc, n_dac, n_proc;
	int          num_errors, compares, cycles, i;
	// status words for ratio codes 0..B at 8k, and rate codes 0..7 at 1024
	logic [15:0] ratio_exp [12] = '{16'h0000, 16'h0090, 16'h00D8, 16'h0120,
		16'h01B0, 16'h01B0, 16'h01B0, 16'h01B0, 16'h01B0, 16'h01B0,
		16'h01B0, 16'h03B0};
	logic [15:0] rate_exp [8] = '{16'h03B0, 16'h03B0, 16'h01B0, 16'h01B0,
		16'h01B0, 16'h01B0, 16'h0520, 16'h0520};

	assign eff = {src, osc, co5s, syn2, syn3, co2d, co5d, co3s};

	auto_clock_config dut
	(
		.SYS_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .PIN_FIVE_I(pin),
		.MASTER_SOURCE_SELECT_O(src), .OSCILLATOR_ENABLE_O(osc),
		.CLOCK_OUTPUT_FIVE_SELECT_O(co5s), .SECOND_SYNTH_ENABLE_O(syn2),
		.THIRD_SYNTH_ENABLE_O(syn3), .CLOCK_OUTPUT_TWO_DIVIDER_O(co2d),
		.CLOCK_OUTPUT_FIVE_DIVIDER_O(co5d),
		.CLOCK_OUTPUT_THREE_SELECT_O(co3s), .PROCESSING_TICK_O(ptick),
		.ADC_TICK_O(atick), .DAC_TICK_O(dtick)
	);

	pin_five_source pin_model
	(
		.level_i(pin_level),
		.pin_o(pin)
	);

	// 25 MHz clock
	always #20 clk = ~clk;

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one-cycle write strobe, taken at the second edge
	task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// extra edge lets derived dividers land before the address is sampled
	task automatic rd_chk(input string what, input logic [6:0] a,
		input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		repeat (2) @(posedge clk);
		#1;
		check(what, exp, rdata);
	endtask

	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard, far above the expected few hundred cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			stop_test();
		end
	end

	initial
	begin
		clk = 1'b0; rst_n = 1'b0; wr = 1'b0; addr = 7'h00;
		wdata = 16'h0000; pin_level = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk("status", 7'h04, 16'h0020);
		rd_chk("rate", 7'h1B, 16'h0010);
		rd_chk("ratio", 7'h38, 16'h0006);
		rd_chk("dac osr", 7'h06, 16'h0000);
		rd_chk("adc osr", 7'h17, 16'h0000);
		rd_chk("clocking", 7'h08, 16'h0000);
		rd_chk("unmapped", 7'h7F, 16'h0000);
		$display("test reset values done");
		// ratio codes 0 to B at 8k, with a write to the status word between;
		// no enhancement is ever on, so ratios under 512 are legal here
		reg_write(7'h1B, 16'h0015);
		for (i = 0; i < 12; i++)
		begin
			reg_write(7'h38, 16'(i << 1));
			reg_write(7'h04, 16'hFFFF);
			rd_chk("ratio", 7'h38, 16'(i << 1));
			rd_chk("status", 7'h04, ratio_exp[i]);
		end
		$display("test ratio codes done");
		// every rate code at ratio 1024, reserved code last
		reg_write(7'h38, 16'h000E);
		for (i = 0; i < 8; i++)
		begin
			reg_write(7'h1B, 16'(16'h0010 | i));
			rd_chk("rate", 7'h1B, 16'(16'h0010 | i));
			rd_chk("status", 7'h04, rate_exp[i]);
		end
		$display("test rate codes done");
		// oversampling bits steer each converter divider on its own
		reg_write(7'h1B, 16'h0000);
		reg_write(7'h06, 16'h0001);
		rd_chk("status", 7'h04, 16'h03A0);
		reg_write(7'h06, 16'h0000);
		reg_write(7'h17, 16'h0020);
		rd_chk("status", 7'h04, 16'h0330);
		rd_chk("adc osr", 7'h17, 16'h0020);
		n_adc = 16'h0000;
		n_dac = 16'h0000;
		n_proc = 16'h0000;
		repeat (240)
		begin
			@(posedge clk);
			#1;
			n_adc = n_adc + {15'h0000, atick};
			n_dac = n_dac + {15'h0000, dtick};
			n_proc = n_proc + {15'h0000, ptick};
		end
		check("proc ticks", 16'h0078, n_proc);
		check("adc ticks", 16'h001E, n_adc);
		check("dac ticks", 16'h0014, n_dac);
		$display("test oversampling done");
		// pin ownership, then override; pin five is left to the clocking
		reg_write(7'h08, 16'h0400);
		rd_chk("clocking", 7'h08, 16'h0400);
		check("controls", 16'h0100, {7'h00, eff});
		@(posedge clk);
		pin_level <= 1'b1;
		repeat (6) @(posedge clk);
		reg_write(7'h08, 16'hF40E);
		rd_chk("clocking", 7'h08, 16'h3200);
		check("controls", 16'h00E0, {7'h00, eff});
		reg_write(7'h08, 16'hF80E);
		@(posedge clk);
		pin_level <= 1'b0;
		repeat (6) @(posedge clk);
		rd_chk("clocking", 7'h08, 16'hFC0E);
		check("controls", 16'h017F, {7'h00, eff});
		$display("test pin ownership done");
		// a second reset must drop the override bit
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk("clocking", 7'h08, 16'h0000);
		rd_chk("status", 7'h04, 16'h0020);
		check("controls", 16'h0000, {7'h00, eff});
		$display("test second reset done");
		stop_test();
	end
endmodule

`default_nettype wire
